// ===== design/lut_port_device.sv
// Contract
// RULE1: Each step is one full strobe pulse.
// RULE2: Direction and select sampled at strobe fall.
// RULE3: Write data captured at strobe rise.
// RULE4: Captured write commits at next strobe fall.
// RULE5: Host ends sequences with control read.
// RULE6: Read drive from fall until rise.
// RULE7: First table read prefetches, data meaningless.
// RULE8: Table read ended by further fall.
// RULE9: Write at select 01 loads index.
// RULE10: Table writes fill components in order.
// RULE11: Table reads return components in order.
// RULE12: Index advances after third component.
// RULE13: Index read shows index, terminates writes.
// RULE14: Index load resets component selector.
`timescale 1ns/10ps
`default_nettype none
module lut_port_device
    import lut_port_pkg::*;
#(
    parameter int ENTRIES = 256
) (
    // System.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Host port.
    lut_port_if.device       port,
    // Lookup output for the video path.
    input  wire logic [7:0]  pixel_index,
    output logic [23:0]      pixel_color,
    // Current index for observation.
    output logic [7:0]       table_index
);
    import lut_port_pkg::*;

    // Pin synchronisers: two flops before any logic reads them.
    logic [11:0] sync1;
    logic [11:0] sync2;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= 12'hfff;
            sync2 <= 12'hfff;
        end else begin
            sync1 <= {port.select_strobe_n, port.read_not_write,
                      port.port_select, port.host_data_bus};
            sync2 <= sync1;
        end
    end

    logic       strobe_n;
    logic       strobe_d;
    logic       s_rnw;
    logic [1:0] s_sel;
    logic [7:0] s_data;
    assign strobe_n = sync2[11];
    assign s_rnw    = sync2[10];
    assign s_sel    = sync2[9:8];
    assign s_data   = sync2[7:0];

    // Edge detection on the synchronised strobe.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            strobe_d <= 1'b1;
        end else begin
            strobe_d <= strobe_n;
        end
    end

    logic fall;
    logic rise;
    assign fall = strobe_d && !strobe_n; // RULE1
    assign rise = !strobe_d && strobe_n; // RULE1

    // Step latched at the fall, write data at the rise.
    logic       step_rnw;
    logic [1:0] step_sel;
    logic       pend_valid;
    logic [1:0] pend_sel;
    logic [7:0] pend_data;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            step_rnw <= 1'b1;
            step_sel <= PORT_CONTROL;
        end else if (fall) begin
            step_rnw <= s_rnw; // RULE2
            step_sel <= s_sel; // RULE2
        end
    end

    // Storage for the three components of each location.
    logic [7:0] comp_mem [3][ENTRIES];
    logic [1:0] component;
    logic [7:0] prefetch [3];
    logic       commit_table;
    logic       commit_index;
    logic       read_table;
    assign commit_table = fall && pend_valid
                          && pend_sel == OFS_TABLE_DATA_PORT;
    assign commit_index = fall && pend_valid
                          && pend_sel == OFS_TABLE_INDEX;
    assign read_table   = fall && s_rnw && s_sel == OFS_TABLE_DATA_PORT;

    // Pending write captured at the rise, committed at next fall.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_valid <= 1'b0;
            pend_sel   <= PORT_CONTROL;
            pend_data  <= 8'h00;
        end else if (rise && !step_rnw) begin
            pend_valid <= 1'b1;
            pend_sel   <= step_sel;
            pend_data  <= s_data; // RULE3
        end else if (fall) begin
            pend_valid <= 1'b0; // RULE4
        end
    end

    // Table writes go to the selected component.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_comp
            always_ff @(posedge clk) begin
                if (commit_table && component == 2'(g)) begin
                    comp_mem[g][table_index] <= pend_data; // RULE10
                end
            end
        end
    endgenerate

    // Read sequence state: armed after the prefetch step.
    logic read_armed;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            read_armed <= 1'b0;
        end else if (fall) begin
            read_armed <= read_table; // RULE7 RULE8
        end
    end

    // Index as it stands once this fall's commit lands. A prefetch on the
    // same fall as an index load or a third-component wrap must use it.
    logic       data_access;
    logic [7:0] next_index;
    assign data_access = commit_table || (read_table && read_armed);
    assign next_index  = commit_index ? pend_data
                       : data_access && component == LAST_COMPONENT
                       ? table_index + 8'h01 : table_index;

    // Prefetch snapshot of the location that the following reads use.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prefetch[0] <= 8'h00;
            prefetch[1] <= 8'h00;
            prefetch[2] <= 8'h00;
        end else if (read_table && !read_armed) begin
            prefetch[0] <= comp_mem[0][next_index]; // RULE7
            prefetch[1] <= comp_mem[1][next_index];
            prefetch[2] <= comp_mem[2][next_index];
        end
    end

    // Index and component selector.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            table_index <= RST_TABLE_INDEX;
            component   <= RST_COMPONENT;
        end else if (commit_index) begin
            table_index <= pend_data; // RULE9
            component   <= RST_COMPONENT; // RULE14
        end else if (read_table && !read_armed) begin
            table_index <= next_index; // RULE12
            component   <= RST_COMPONENT;
        end else if (data_access) begin
            if (component == LAST_COMPONENT) begin
                component   <= RST_COMPONENT;
                table_index <= table_index + 8'h01; // RULE12
            end else begin
                component   <= component + 2'h1;
            end
        end
    end

    // Read data and drive window from fall to rise.
    logic [7:0] rd_data;
    logic       drive;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= 8'h00;
            drive   <= 1'b0;
        end else if (fall && s_rnw) begin
            drive <= 1'b1; // RULE6
            case (s_sel)
                OFS_TABLE_INDEX: rd_data <= next_index; // RULE13
                OFS_TABLE_DATA_PORT: rd_data <= read_armed
                    ? prefetch[component] : 8'h00; // RULE11
                default: rd_data <= 8'h00;
            endcase
        end else if (rise) begin
            drive <= 1'b0; // RULE6
        end
    end
    assign port.dev_data_out  = rd_data;
    assign port.dev_data_oe_n = !drive;

    // Video-path lookup, one cycle latency.
    always_ff @(posedge clk) begin
        pixel_color <= {comp_mem[0][pixel_index],
                        comp_mem[1][pixel_index],
                        comp_mem[2][pixel_index]};
    end

endmodule : lut_port_device
`default_nettype wire

// ===== design/lut_port_pkg.sv
package lut_port_pkg;

    // Port select codes sampled at the strobe falling edge.
    localparam logic [1:0] PORT_CONTROL = 2'h0;
    localparam logic [1:0] PORT_INDEX   = 2'h1;
    localparam logic [1:0] PORT_SPARE   = 2'h2;
    localparam logic [1:0] PORT_TABLE   = 2'h3;

    // Register offsets as seen on port_select.
    localparam logic [1:0] OFS_TABLE_INDEX     = 2'h1;
    localparam logic [1:0] OFS_TABLE_DATA_PORT = 2'h3;

    // Reset values and the last component selector value.
    localparam logic [7:0] RST_TABLE_INDEX = 8'h00;
    localparam logic [1:0] RST_COMPONENT   = 2'h0;
    localparam logic [1:0] LAST_COMPONENT  = 2'h2;

    // Strobe timing at 100 MHz.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STROBE_LOW_NS   = 55;
    localparam int STROBE_HIGH_NS  = 30;
    localparam int STROBE_LOW_CYC  =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC =
        (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host end sequencer states.
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_SETUP = 4'b0010,
        H_LOW   = 4'b0100,
        H_HIGH  = 4'b1000
    } host_state_t;

endpackage : lut_port_pkg

// ===== design/lut_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lut_port_if;
    logic       select_strobe_n;
    logic       read_not_write;
    logic [1:0] port_select;
    logic [7:0] host_data_out;
    logic       host_data_oe_n;
    logic [7:0] dev_data_out;
    logic       dev_data_oe_n;
    wire  [7:0] host_data_bus;

    // Resolved bus level; active-low enables, device wins on read.
    assign host_data_bus = !dev_data_oe_n  ? dev_data_out  :
                           !host_data_oe_n ? host_data_out : 8'h00;

    modport device (
        input  select_strobe_n,
        input  read_not_write,
        input  port_select,
        input  host_data_bus,
        output dev_data_out,
        output dev_data_oe_n
    );

    modport host (
        output select_strobe_n,
        output read_not_write,
        output port_select,
        output host_data_out,
        output host_data_oe_n,
        input  host_data_bus
    );
endinterface : lut_port_if
`default_nettype wire

// ===== design/lut_port_host.sv
`timescale 1ns/10ps
`default_nettype none
module lut_port_host
    import lut_port_pkg::*;
(
    // System.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Step request from user logic.
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_read,
    input  wire logic [1:0]  req_select,
    input  wire logic [7:0]  req_wdata,
    // Step result.
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    // Device port.
    lut_port_if.host         port
);
    import lut_port_pkg::*;

    host_state_t state;
    logic [3:0]  cnt;
    logic        rnw;
    logic [1:0]  sel;
    logic [7:0]  wdata;
    logic        strobe_n;
    logic [7:0]  bus_s1;
    logic [7:0]  bus_s2;

    assign req_ready = state == H_IDLE;

    // Step sequencer: select set up, strobe low, strobe high.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state    <= H_IDLE;
            cnt      <= 4'h0;
            strobe_n <= 1'b1;
            rnw      <= 1'b1;
            sel      <= PORT_CONTROL;
            wdata    <= 8'h00;
        end else begin
            case (state)
                H_IDLE: if (req_valid) begin
                    rnw   <= req_read; // RULE2
                    sel   <= req_select; // RULE5 RULE7 RULE9
                    wdata <= req_wdata; // RULE3
                    state <= H_SETUP;
                end
                H_SETUP: begin
                    strobe_n <= 1'b0; // RULE1
                    cnt      <= 4'(STROBE_LOW_CYC + 2);
                    state    <= H_LOW;
                end
                H_LOW: if (cnt == 4'h0) begin
                    strobe_n <= 1'b1; // RULE1
                    cnt      <= 4'(STROBE_HIGH_CYC + 2);
                    state    <= H_HIGH;
                end else begin
                    cnt <= cnt - 4'h1;
                end
                H_HIGH: if (cnt == 4'h0) begin
                    state <= H_IDLE; // RULE8
                end else begin
                    cnt <= cnt - 4'h1;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // Read data synchronised, sampled just before the strobe rises.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_s1    <= 8'h00;
            bus_s2    <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            bus_s1    <= port.host_data_bus;
            bus_s2    <= bus_s1;
            rsp_valid <= state == H_LOW && cnt == 4'h0;
            if (state == H_LOW && cnt == 4'h0 && rnw) begin
                rsp_rdata <= bus_s2;
            end
        end
    end

    assign port.select_strobe_n = strobe_n;
    assign port.read_not_write  = rnw;
    assign port.port_select     = sel;
    assign port.host_data_out   = wdata;
    assign port.host_data_oe_n  = rnw; // RULE3

endmodule : lut_port_host
`default_nettype wire

// ===== verification/lut_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module lut_port_chk (
    // System.
    input wire logic       clk,
    input wire logic       rstn,
    // Port pins.
    input wire logic       select_strobe_n,
    input wire logic       read_not_write,
    input wire logic [1:0] port_select,
    input wire logic [7:0] host_data_bus,
    input wire logic       host_data_oe_n,
    input wire logic       dev_data_oe_n
);
    // All checks run on the system clock and pause in reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_low_len;
        $fell(select_strobe_n) |-> !select_strobe_n [*6];
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("strobe low phase too short");
    property p_high_len;
        $rose(select_strobe_n) |-> select_strobe_n [*3];
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("strobe high phase too short");
    property p_ctl_hold;
        !select_strobe_n && !$fell(select_strobe_n)
            |-> $stable(read_not_write) && $stable(port_select);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold)
        else $error("direction or select moved while strobe low");
    property p_wdata_hold;
        $rose(select_strobe_n) && !read_not_write
            |-> !host_data_oe_n && $stable(host_data_bus);
    endproperty
    a_wdata_hold: assert property (p_wdata_hold)
        else $error("write data not held at strobe rise");
    property p_drv_start;
        $fell(select_strobe_n) && read_not_write |-> ##[2:6] !dev_data_oe_n;
    endproperty
    a_drv_start: assert property (p_drv_start)
        else $error("device did not drive on read");
    property p_drv_stop;
        $rose(select_strobe_n) |-> ##[2:6] dev_data_oe_n;
    endproperty
    a_drv_stop: assert property (p_drv_stop)
        else $error("device kept driving after strobe rise");
    property p_drv_dir;
        $fell(dev_data_oe_n) |-> read_not_write && !select_strobe_n;
    endproperty
    a_drv_dir: assert property (p_drv_dir)
        else $error("device drove outside a read");
    property p_no_clash;
        !(!dev_data_oe_n && !host_data_oe_n);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data bus");

    // Main traffic kinds.
    c_read: cover property ($fell(select_strobe_n) && read_not_write);
    c_write: cover property ($fell(select_strobe_n) && !read_not_write);
    c_table: cover property ($fell(select_strobe_n) && port_select == 2'h3);
endmodule : lut_port_chk
`default_nettype wire

// ===== verification/host_port_lookup_table_access_test.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_lookup_table_access_test;
    import lut_port_pkg::*;
    logic        clk;
    logic        rstn;
    logic        req_valid;
    logic        req_ready;
    logic        req_read;
    logic [1:0]  req_select;
    logic [7:0]  req_wdata;
    logic        rsp_valid;
    logic [7:0]  rsp_rdata;
    logic [7:0]  pixel_index;
    logic [23:0] pixel_color;
    logic [7:0]  table_index;
    logic [7:0]  got;
    int          num_errors;
    int          compares;

    lut_port_if lut_port_if_i ();
    lut_port_host lut_port_host_i (.clk(clk), .rstn(rstn),
        .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
        .req_select(req_select), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .port(lut_port_if_i));
    lut_port_device #(.ENTRIES(256)) lut_port_device_i (.clk(clk),
        .rstn(rstn), .port(lut_port_if_i), .pixel_index(pixel_index),
        .pixel_color(pixel_color), .table_index(table_index));
    lut_port_chk lut_port_chk_i (.clk(clk), .rstn(rstn),
        .select_strobe_n(lut_port_if_i.select_strobe_n),
        .read_not_write(lut_port_if_i.read_not_write),
        .port_select(lut_port_if_i.port_select),
        .host_data_bus(lut_port_if_i.host_data_bus),
        .host_data_oe_n(lut_port_if_i.host_data_oe_n),
        .dev_data_oe_n(lut_port_if_i.dev_data_oe_n));

    // Free-running system clock.
    always #5 clk = ~clk;

    task chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk8

    task chk24(input logic [23:0] g, input logic [23:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t color %h expected %h", $time, g, e);
        end
    endtask : chk24

    // One full strobe step through the host end; read data lands in got.
    task step(input logic rd, input logic [1:0] sel, input logic [7:0] wd);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge clk); #1; n++;
        end
        chk8({7'h00, req_ready}, 8'h01);
        req_valid = 1'b1;
        req_read = rd;
        req_select = sel;
        req_wdata = wd;
        @(posedge clk); #1;
        req_valid = 1'b0;
        chk8({7'h00, req_ready}, 8'h00);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge clk); #1; n++;
        end
        chk8({7'h00, rsp_valid}, 8'h01);
        got = rsp_rdata;
    endtask : step

    task pix(input logic [7:0] i, input logic [23:0] e);
        pixel_index = i;
        @(posedge clk); @(posedge clk); #1;
        chk24(pixel_color, e);
    endtask : pix

    task t_index;
        step(1'b0, PORT_INDEX, 8'h5a);
        chk8(table_index, 8'h00);
        step(1'b1, PORT_INDEX, 8'h00);
        chk8(got, 8'h5a);
        chk8(table_index, 8'h5a);
    endtask : t_index

    task t_table;
        step(1'b0, PORT_INDEX, 8'h10);
        for (int k = 1; k < 4; k++) step(1'b0, PORT_TABLE, 8'(8'h11 * k));
        step(1'b1, PORT_INDEX, 8'h00);
        chk8(got, 8'h11);
        step(1'b0, PORT_INDEX, 8'h10);
        step(1'b1, PORT_TABLE, 8'h00);
        chk8(got, 8'h00);
        for (int k = 1; k < 4; k++) begin
            step(1'b1, PORT_TABLE, 8'h00);
            chk8(got, 8'(8'h11 * k));
        end
        step(1'b1, PORT_CONTROL, 8'h00);
        chk8(got, 8'h00);
        pix(8'h10, 24'h112233);
    endtask : t_table

    task t_restart;
        step(1'b0, PORT_INDEX, 8'h20);
        step(1'b0, PORT_TABLE, 8'hee);
        step(1'b0, PORT_INDEX, 8'h20);
        for (int k = 4; k < 7; k++) step(1'b0, PORT_TABLE, 8'(8'h11 * k));
        step(1'b1, PORT_CONTROL, 8'h00);
        pix(8'h20, 24'h445566);
        chk8(table_index, 8'h21);
    endtask : t_restart

    task t_fill;
        step(1'b0, PORT_INDEX, 8'h00);
        for (int k = 0; k < 768; k++) step(1'b0, PORT_TABLE, 8'(k) ^ 8'h5c);
        step(1'b1, PORT_CONTROL, 8'h00);
        chk8(table_index, 8'h00);
        for (int e = 0; e < 256; e++)
            pix(8'(e), {8'(3 * e) ^ 8'h5c, 8'(3 * e + 1) ^ 8'h5c,
                        8'(3 * e + 2) ^ 8'h5c});
    endtask : t_fill

    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Cuts a hang short well past the expected run length.
    initial begin
        #400us;
        num_errors++;
        results();
    end

    // Reset, then the scenarios in turn.
    initial begin
        {clk, rstn, req_valid, req_read, num_errors, compares} = '0;
        {req_select, req_wdata, pixel_index} = '0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk); #1;
        t_index();
        t_table();
        t_restart();
        t_fill();
        results();
    end
endmodule : host_port_lookup_table_access_test
`default_nettype wire
